//--- touch_scan_pkg.sv
// Constants, types and lookup functions of the touch scan scheduler
package touch_scan_pkg;

  localparam int KEY_COUNT = 48;
  localparam int KEY_W = 6;
  localparam int SIG_W = 11;
  localparam int TIMER_W = 25;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int SYNC_WAIT_MS = 100;
  localparam int SYNC_WAIT_CYC = SYNC_WAIT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int INIT_CYC = 16;

  // Setup reset values
  localparam logic [3:0] DWELL_DEF = 4'h1;
  localparam logic SYNC_EN_DEF = 1'h0;
  localparam logic RESTART_DEF = 1'h0;
  localparam logic [2:0] DRIFT_DEF = 3'h0;
  localparam logic [2:0] RATE_DEF = 3'h0;
  localparam logic [10:0] LIMIT_DEF = 11'h064;
  localparam logic [3:0] GAIN_THR_DEF = 4'h7;

  typedef struct packed {
    logic [3:0] dwell;
    logic mains_sync_enable;
    logic burst_restart_enable;
    logic [2:0] sleep_drift_interval;
    logic [2:0] serial_rate_select;
    logic [10:0] lower_signal_limit;
    logic [3:0] gain_test_threshold;
  } setup_t;

  localparam setup_t SETUP_DEFAULT = '{DWELL_DEF, SYNC_EN_DEF, RESTART_DEF, DRIFT_DEF, RATE_DEF,
                                       LIMIT_DEF, GAIN_THR_DEF};

  typedef struct packed {
    logic done;
    logic [10:0] signal;
    logic [10:0] reference;
  } afe_result_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_SYNC_WAIT = 3'b001,
    ST_BURST = 3'b010,
    ST_NEXT = 3'b011,
    ST_HOST = 3'b100,
    ST_SLEEP = 3'b101
  } state_t;

  // Dwell code to capture time in ns
  function automatic int dwell_ns(input logic [3:0] code);
    case (code)
      4'h0: dwell_ns = 125;
      4'h1: dwell_ns = 188;
      4'h2: dwell_ns = 250;
      4'h3: dwell_ns = 313;
      4'h4: dwell_ns = 375;
      4'h5: dwell_ns = 500;
      4'h6: dwell_ns = 625;
      4'h7: dwell_ns = 750;
      4'h8: dwell_ns = 1000;
      4'h9: dwell_ns = 1250;
      4'hA: dwell_ns = 1875;
      4'hB: dwell_ns = 2500;
      4'hC: dwell_ns = 3750;
      4'hD: dwell_ns = 5000;
      4'hE: dwell_ns = 7500;
      default: dwell_ns = 9900;
    endcase
  endfunction

  // Least time, so round up
  function automatic logic [11:0] dwell_cycles(input logic [3:0] code);
    dwell_cycles = 12'((dwell_ns(code) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [15:0] baud_divisor(input logic [2:0] code);
    int baud;
    case (code)
      3'h1: baud = 19200;
      3'h2: baud = 38400;
      3'h3: baud = 57600;
      3'h4: baud = 115200;
      default: baud = 9600;
    endcase
    baud_divisor = 16'(CLK_HZ / baud);
  endfunction

  function automatic logic [6:0] gain_threshold(input logic [3:0] idx);
    gain_threshold = 7'((idx + 5'h01) * 4);
  endfunction

  function automatic logic [6:0] drift_period(input logic [2:0] code);
    drift_period = (code == 3'h0) ? 7'h01 : 7'(7'h01 << (code - 3'h1));
  endfunction

  // Lowest enabled key at or above start, KEY_COUNT when none
  function automatic logic [KEY_W:0] next_key(input logic [KEY_COUNT-1:0] en, input logic [KEY_W:0] start);
    next_key = (KEY_W + 1)'(KEY_COUNT);
    for (int i = KEY_COUNT - 1; i >= 0; i--) begin
      if (en[i] && (i >= int'(start))) begin
        next_key = (KEY_W + 1)'(i);
      end
    end
  endfunction

endpackage

//--- key_signal_mem.sv
// Per-key normal signal store with registered read
`timescale 1ns/1ps
`default_nettype none
module key_signal_mem
  import touch_scan_pkg::*;
(
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [KEY_W-1:0] wr_addr,
  input wire logic [SIG_W-1:0] wr_data,
  input wire logic [KEY_W-1:0] rd_addr,
  output logic [SIG_W-1:0] rd_data_q
);

  logic [SIG_W-1:0] mem [KEY_COUNT];

  always_ff @(posedge mclk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (clk_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

//--- touch_scan_sync_setup.sv
// Scan scheduler: mains sync, burst restart, sleep, setup lookups
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 4-bit dwell code sets capture time, default 188ns
// - Sync wait only before lowest enabled key
// - Awake: wait 100 ms for sync, rescan
// - Asleep with sync: wait without limit
// - Sleep off: falling sync edge starts burst
// - Sleep on: low level triggers, repeats while low
// - Sleep and sync: wake, scan, sleep again
// - Sync timeout: continue scanning, set error flag
// - After reset with sync: error, then wait
// - Mains sync enable bit, default off
// - Restart on: abort burst, serve host, restart
// - Restart off: finish burst, stretch ready low
// - Burst restart bit, default off
// - Sleep stops clock, scanning and timers
// - Drift field: 0 no sleep, else 2^(n-1)
// - Five UART rates, default 9600, SPI unaffected
// - SPI slave only, clock up to 4 MHz
// - Reference below lower limit flags key error
// - Gain test: half burst, normal minus test
// - Gain threshold index maps 4..64, default 32
module touch_scan_sync_setup
  import touch_scan_pkg::*;
#(
  parameter int SYNC_WAIT_CYCLES = SYNC_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic setup_load,
  input wire setup_t setup_in,
  input wire logic [KEY_COUNT-1:0] key_enable,
  input wire logic wake_sync_input,
  input wire logic host_req,
  input wire logic host_done,
  input wire logic sleep_req,
  input wire logic status_read,
  input wire logic gain_test_start,
  input wire afe_result_t afe,
  output logic burst_start_q,
  output logic [KEY_W-1:0] burst_key_q,
  output logic burst_half_q,
  output logic burst_abort_q,
  output logic [11:0] dwell_cycles_q,
  output logic [15:0] baud_div_q,
  output logic host_grant_q,
  output logic host_data_ready_line_n_q,
  output logic osc_run_q,
  output logic scan_done_q,
  output logic sync_error_q,
  output logic drift_comp_q,
  output logic [KEY_COUNT-1:0] key_limit_error_q,
  output logic [KEY_COUNT-1:0] gain_pass_q,
  output logic gain_test_busy_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  setup_t setup_q;
  state_t state_q, state_d, resume_q, resume_d;
  logic [KEY_W-1:0] key_q, key_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic wake_prev_q;
  logic [6:0] sleep_cnt_q;
  logic gt_pend_q, gt_run_q;
  logic [SIG_W-1:0] normal_sig;
  logic sync_err_set, scan_start, scan_end, enter_sleep, wake_now;

  wire sleep_on = setup_q.sleep_drift_interval != 3'h0;
  wire sync_on = setup_q.mains_sync_enable;
  wire restart_on = setup_q.burst_restart_enable;
  wire wake_fall = wake_prev_q & ~wake_sync_input;
  // Level trigger when sleep may be used, edge otherwise
  wire sync_evt = sleep_on ? ~wake_sync_input : wake_fall;
  wire [KEY_W:0] first_k = next_key(key_enable, '0);
  wire [KEY_W:0] next_k = next_key(key_enable, (KEY_W + 1)'(key_q) + 7'h01);
  wire first_ok = first_k < (KEY_W + 1)'(KEY_COUNT);
  wire next_ok = next_k < (KEY_W + 1)'(KEY_COUNT);
  wire timeout = timer_q >= TIMER_W'(SYNC_WAIT_CYCLES - 1);
  wire abort = (state_q == ST_BURST) && host_req && restart_on;
  wire burst_end = (state_q == ST_BURST) && afe.done && !abort;
  wire [6:0] drift_per = drift_period(setup_q.sleep_drift_interval);
  wire [SIG_W:0] gain_need = {1'b0, afe.signal} + {5'h00, gain_threshold(setup_q.gain_test_threshold)};
  wire gain_ok = {1'b0, normal_sig} >= gain_need;

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer

  always_comb begin
    state_d = state_q;
    resume_d = resume_q;
    key_d = key_q;
    timer_d = timer_q;
    sync_err_set = 1'b0;
    scan_start = 1'b0;
    scan_end = 1'b0;
    enter_sleep = 1'b0;
    wake_now = 1'b0;
    case (state_q)
      ST_INIT: begin
        timer_d = timer_q + 1'b1;
        if (timer_q == TIMER_W'(INIT_CYC - 1)) begin
          timer_d = '0;
          if (sync_on) begin
            sync_err_set = 1'b1;
            state_d = ST_SYNC_WAIT;
          end else begin
            scan_start = 1'b1;
          end
        end
      end
      ST_SYNC_WAIT: begin
        if (host_req) begin
          resume_d = ST_SYNC_WAIT;
          state_d = ST_HOST;
        end else if (sync_evt) begin
          scan_start = 1'b1;
        end else if (timeout) begin
          sync_err_set = 1'b1;
          scan_start = 1'b1;
        end else begin
          timer_d = timer_q + 1'b1;
        end
      end
      ST_BURST: begin
        if (abort) begin
          resume_d = ST_BURST;
          state_d = ST_HOST;
        end else if (afe.done) begin
          state_d = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (host_req) begin
          resume_d = ST_NEXT;
          state_d = ST_HOST;
        end else if (next_ok) begin
          key_d = next_k[KEY_W-1:0];
          state_d = ST_BURST;
        end else begin
          scan_end = 1'b1;
        end
      end
      ST_HOST: begin
        if (host_done) begin
          state_d = resume_q;
        end
      end
      ST_SLEEP: begin
        if (host_req) begin
          resume_d = ST_SLEEP;
          state_d = ST_HOST;
        end else if (~wake_sync_input) begin
          wake_now = 1'b1;
          scan_start = 1'b1;
        end
      end
      default: begin
        state_d = ST_INIT;
        timer_d = '0;
      end
    endcase
    if (scan_end) begin
      timer_d = '0;
      if (sleep_on && sleep_req) begin
        enter_sleep = 1'b1;
        state_d = ST_SLEEP;
      end else if (sync_on) begin
        state_d = ST_SYNC_WAIT;
      end else begin
        scan_start = 1'b1;
      end
    end
    if (scan_start) begin
      timer_d = '0;
      key_d = first_k[KEY_W-1:0];
      state_d = first_ok ? ST_BURST : ST_NEXT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_INIT;
      resume_q <= ST_NEXT;
      key_q <= '0;
      timer_q <= '0;
      wake_prev_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      resume_q <= resume_d;
      key_q <= key_d;
      timer_q <= timer_d;
      wake_prev_q <= wake_sync_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup and lookups; SPI side untouched by the rate code

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      setup_q <= SETUP_DEFAULT;
      dwell_cycles_q <= dwell_cycles(DWELL_DEF);
      baud_div_q <= baud_divisor(RATE_DEF);
    end else if (clk_en) begin
      if (setup_load) begin
        setup_q <= setup_in;
      end
      dwell_cycles_q <= dwell_cycles(setup_q.dwell);
      baud_div_q <= baud_divisor(setup_q.serial_rate_select);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host handshake and burst outputs

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      burst_start_q <= 1'b0;
      burst_key_q <= '0;
      burst_abort_q <= 1'b0;
      host_grant_q <= 1'b0;
      host_data_ready_line_n_q <= 1'b1;
      osc_run_q <= 1'b1;
      scan_done_q <= 1'b0;
    end else if (clk_en) begin
      burst_start_q <= (state_d == ST_BURST) && (state_q != ST_BURST);
      burst_key_q <= key_d;
      burst_abort_q <= abort;
      host_grant_q <= state_d == ST_HOST;
      // Held low while the host waits on a running burst
      host_data_ready_line_n_q <= ~(host_req && (state_d != ST_HOST));
      osc_run_q <= state_d != ST_SLEEP;
      scan_done_q <= scan_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync error flag, set wins over the status read

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync_error_q <= 1'b0;
    end else if (clk_en) begin
      sync_error_q <= sync_err_set | (sync_error_q & ~status_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep counting and drift compensation

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sleep_cnt_q <= '0;
      drift_comp_q <= 1'b0;
    end else if (clk_en) begin
      drift_comp_q <= 1'b0;
      if (wake_now) begin
        if (sleep_cnt_q >= drift_per - 7'h01) begin
          sleep_cnt_q <= '0;
          drift_comp_q <= 1'b1;
        end else begin
          sleep_cnt_q <= sleep_cnt_q + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-key results and gain test

  key_signal_mem u_mem (
    .mclk(mclk),
    .clk_en(clk_en),
    .wr_en(burst_end && !gt_run_q),
    .wr_addr(key_q),
    .wr_data(afe.signal),
    .rd_addr(key_q),
    .rd_data_q(normal_sig)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gt_pend_q <= 1'b0;
      gt_run_q <= 1'b0;
      burst_half_q <= 1'b0;
      gain_test_busy_q <= 1'b0;
      gain_pass_q <= '0;
      key_limit_error_q <= '0;
    end else if (clk_en) begin
      if (gain_test_start) begin
        gt_pend_q <= 1'b1;
      end else if (scan_start) begin
        gt_pend_q <= 1'b0;
      end
      if (scan_start) begin
        gt_run_q <= gt_pend_q | gain_test_start;
      end else if (scan_end) begin
        gt_run_q <= 1'b0;
      end
      if (scan_start && (gt_pend_q | gain_test_start)) begin
        gain_pass_q <= '0;
      end else if (burst_end && gt_run_q) begin
        gain_pass_q[key_q] <= gain_ok;
      end
      if (burst_end && !gt_run_q) begin
        key_limit_error_q[key_q] <= afe.reference < setup_q.lower_signal_limit;
      end
      burst_half_q <= gt_run_q;
      gain_test_busy_q <= gt_run_q | gt_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_dwell_default;
    clk_en && setup_load && setup_in.dwell == DWELL_DEF ##1 clk_en |=> dwell_cycles_q == 12'h02F;
  endproperty
  a_dwell_default: assert property (p_dwell_default) else $error("dwell 1 not 47 cycles");

  property p_sync_first_key;
    clk_en && state_q == ST_SYNC_WAIT && state_d == ST_BURST |=> key_q == first_k[KEY_W-1:0];
  endproperty
  a_sync_first_key: assert property (p_sync_first_key) else $error("sync not at lowest key");

  property p_wait_bound;
    state_q == ST_SYNC_WAIT |-> timer_q < TIMER_W'(SYNC_WAIT_CYCLES);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("sync wait too long");

  property p_edge_only;
    clk_en && state_q == ST_SYNC_WAIT && !sleep_on && wake_prev_q && wake_sync_input && !timeout && !host_req
      |=> state_q == ST_SYNC_WAIT;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("left wait without edge");

  property p_timeout_error;
    clk_en && state_q == ST_SYNC_WAIT && timeout && !sync_evt && !host_req |=> sync_error_q && state_q != ST_SYNC_WAIT;
  endproperty
  a_timeout_error: assert property (p_timeout_error) else $error("timeout without error");

  property p_init_error;
    clk_en && state_q == ST_INIT && state_d == ST_SYNC_WAIT |=> sync_error_q;
  endproperty
  a_init_error: assert property (p_init_error) else $error("no error after init");

  property p_abort;
    clk_en && state_q == ST_BURST && host_req && restart_on |=> burst_abort_q && host_grant_q;
  endproperty
  a_abort: assert property (p_abort) else $error("burst not aborted");

  property p_stretch;
    clk_en && state_q == ST_BURST && !restart_on && host_req && !afe.done |=> state_q == ST_BURST && !host_data_ready_line_n_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("burst not held");

  property p_sleep_halt;
    clk_en && state_d == ST_SLEEP |=> !osc_run_q;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("clock runs in sleep");

  property p_sleep_needs_drift;
    state_q != ST_SLEEP && state_d == ST_SLEEP |-> sleep_on;
  endproperty
  a_sleep_needs_drift: assert property (p_sleep_needs_drift) else $error("sleep while disabled");

  property p_limit;
    clk_en && burst_end && !gt_run_q && afe.reference < setup_q.lower_signal_limit |=> key_limit_error_q[$past(key_q)];
  endproperty
  a_limit: assert property (p_limit) else $error("limit error missed");

  c_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_BURST);
  c_abort: cover property (burst_abort_q ##[1:20] burst_start_q);
  c_timeout: cover property (state_q == ST_SYNC_WAIT && timeout);
  c_gain_pass: cover property (gain_test_busy_q && |gain_pass_q);

endmodule
`default_nettype wire

//--- afe_partner.sv
// Behavioural sensing front end that answers each burst not aborted after a set delay
`timescale 1ns/1ps
`default_nettype none
module afe_partner
  import touch_scan_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic burst_start_q,
  input wire logic burst_abort_q,
  input wire logic burst_half_q,
  input wire logic [7:0] delay,
  input wire logic [10:0] sig_norm,
  input wire logic [10:0] ref_val,
  input wire logic [6:0] drop,
  output var afe_result_t afe
);
  logic [7:0] cnt_q;
  logic busy_q;
  ////////////////////////////////////////
  // Idle data lines toggle so a stale result never looks valid
  always_ff @(posedge mclk) begin
    afe <= '{1'b0, ~afe.signal, ~afe.reference};
    if (!resetn) begin
      afe <= '0;
      busy_q <= 1'b0;
    end else if (burst_abort_q) begin
      busy_q <= 1'b0;
    end else if (burst_start_q) begin
      busy_q <= 1'b1;
      cnt_q <= delay;
    end else if (busy_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      afe <= '{1'b1, burst_half_q ? sig_norm - 11'(drop) : sig_norm, ref_val};
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Randomised self-checking bench for the scan scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import touch_scan_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic setup_load = 1'b0;
  setup_t setup_in = SETUP_DEFAULT;
  setup_t s;
  logic [KEY_COUNT-1:0] key_enable = '0;
  logic wake_sync_input = 1'b1;
  logic host_req = 1'b0;
  logic host_done = 1'b0;
  logic sleep_req = 1'b1;
  logic status_read = 1'b0;
  logic gain_test_start = 1'b0;
  afe_result_t afe;
  logic [7:0] delay = 8'h04;
  logic [10:0] sig_norm = 11'h3E8;
  logic [10:0] ref_val = 11'h1F4;
  logic [6:0] drop = 7'h00;
  logic burst_start_q, burst_half_q, burst_abort_q, host_grant_q, host_data_ready_line_n_q;
  logic osc_run_q, scan_done_q, sync_error_q, drift_comp_q, gain_test_busy_q;
  logic [KEY_W-1:0] burst_key_q;
  logic [11:0] dwell_cycles_q;
  logic [15:0] baud_div_q;
  logic [KEY_COUNT-1:0] key_limit_error_q, gain_pass_q;
  int mismatches = 0;
  int cmp_count = 0;
  int comp_n = 0;
  int dns[16] = '{125, 188, 250, 313, 375, 500, 625, 750, 1000, 1250, 1875, 2500, 3750, 5000, 7500, 9900};
  int brate[8] = '{9600, 19200, 38400, 57600, 115200, 9600, 9600, 9600};
  wire [8:0] ev = {gain_test_busy_q, afe.done, burst_abort_q, drift_comp_q, osc_run_q, sync_error_q,
                   host_grant_q, scan_done_q, burst_start_q};

  touch_scan_sync_setup #(.SYNC_WAIT_CYCLES(200)) touch_scan_sync_setup_i (
    .mclk, .resetn, .clk_en, .setup_load, .setup_in, .key_enable, .wake_sync_input, .host_req,
    .host_done, .sleep_req, .status_read, .gain_test_start, .afe, .burst_start_q, .burst_key_q,
    .burst_half_q, .burst_abort_q, .dwell_cycles_q, .baud_div_q, .host_grant_q,
    .host_data_ready_line_n_q, .osc_run_q, .scan_done_q, .sync_error_q, .drift_comp_q,
    .key_limit_error_q, .gain_pass_q, .gain_test_busy_q
  );
  afe_partner afe_partner_i (
    .mclk, .resetn, .burst_start_q, .burst_abort_q, .burst_half_q, .delay, .sig_norm, .ref_val,
    .drop, .afe
  );

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (drift_comp_q === 1'b1) comp_n <= comp_n + 1;
  ////////////////////////////////////////
  function automatic logic [11:0] exp_dwell(input int c);
    return 12'((dns[c] + 3) / 4);
  endfunction
  function automatic logic [15:0] exp_baud(input int c);
    return 16'(CLK_HZ / brate[c]);
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait; a miss is reported through the comparison
  task automatic wait_ev(input int b, input logic v, input int lim);
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ev[b] !== v && n < lim);
    chk(ev[b], v);
  endtask
  task automatic hold_ev(input int b, input logic v, input int n);
    logic ok = 1'b1;
    repeat (n) begin
      @(posedge mclk);
      if (ev[b] !== v) ok = 1'b0;
    end
    chk(ok, 1'b1);
  endtask
  task automatic load(input setup_t v);
    setup_in <= v;
    setup_load <= 1'b1;
    @(posedge mclk);
    setup_load <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic release_host();
    host_done <= 1'b1;
    host_req <= 1'b0;
    @(posedge mclk);
    host_done <= 1'b0;
  endtask
  // Short low pulse: the source keeps it under one scan time
  task automatic wake_once();
    wake_sync_input <= 1'b0;
    wait_ev(0, 1, 10);
    wake_sync_input <= 1'b1;
    wait_ev(4, 0, 300);
  endtask
  ////////////////////////////////////////
  initial begin
    int lo;
    int k;
    int idx;
    void'($urandom(13));
    lo = $urandom_range(15);
    key_enable <= (48'h1 << lo) | (48'h1 << (16 + $urandom_range(15))) | (48'h1 << (32 + $urandom_range(15)));
    delay <= 8'($urandom_range(9, 2));
    s = SETUP_DEFAULT;
    repeat (20) @(posedge mclk);
    chk(dwell_cycles_q, exp_dwell(1));
    chk(baud_div_q, exp_baud(0));
    chk(sync_error_q, 1'b0);
    resetn <= 1'b1;
    s.mains_sync_enable = 1'b1;
    load(s);
    wait_ev(3, 1, 30);
    hold_ev(0, 0, 150);
    wait_ev(0, 1, 80);
    chk(burst_key_q, 48'(lo));
    wait_ev(7, 1, 20);
    wait_ev(0, 1, 4);
    status_read <= 1'b1;
    @(posedge mclk);
    status_read <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(sync_error_q, 1'b0);
    wait_ev(1, 1, 200);
    hold_ev(0, 0, 100);
    wake_sync_input <= 1'b0;
    wait_ev(0, 1, 5);
    wake_sync_input <= 1'b1;
    chk(burst_key_q, 48'(lo));
    wait_ev(1, 1, 200);
    wait_ev(0, 1, 220);
    chk(sync_error_q, 1'b1);
    chk(osc_run_q, 1'b1);
    // Sleep with sync, compensation every second wake
    s.sleep_drift_interval = 3'h2;
    load(s);
    wait_ev(4, 0, 500);
    hold_ev(4, 0, 300);
    k = comp_n;
    repeat (4) wake_once();
    chk(comp_n - k, 2);
    wake_sync_input <= 1'b0;
    wait_ev(1, 1, 300);
    wait_ev(1, 1, 300);
    @(posedge mclk);
    chk(osc_run_q, 1'b1);
    s.sleep_drift_interval = 3'h0;
    s.mains_sync_enable = 1'b0;
    load(s);
    wake_sync_input <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      s.dwell = 4'(c);
      s.serial_rate_select = 3'(c);
      load(s);
      chk(dwell_cycles_q, exp_dwell(c));
      chk(baud_div_q, exp_baud(c % 8));
    end
    // Slow bursts so the host lands mid-burst
    delay <= 8'h1E;
    for (int r = 1; r >= 0; r--) begin
      s.burst_restart_enable = 1'(r);
      load(s);
      wait_ev(0, 1, 300);
      k = burst_key_q;
      host_req <= 1'b1;
      if (r == 1) begin
        wait_ev(6, 1, 3);
        wait_ev(2, 1, 3);
      end else begin
        wait_ev(7, 1, 40);
        chk(host_grant_q, 1'b0);
        chk(host_data_ready_line_n_q, 1'b0);
        wait_ev(2, 1, 4);
      end
      release_host();
      wait_ev(0, 1, 10);
      if (r == 1) chk(burst_key_q, 48'(k));
    end
    delay <= 8'($urandom_range(9, 2));
    s.lower_signal_limit = 11'($urandom_range(2047, 1));
    load(s);
    for (int p = 0; p < 2; p++) begin
      ref_val <= s.lower_signal_limit - 11'(1 - p);
      wait_ev(1, 1, 300);
      wait_ev(1, 1, 300);
      chk(key_limit_error_q, p == 1 ? 48'h0 : key_enable);
    end
    idx = $urandom_range(15);
    s.gain_test_threshold = 4'(idx);
    load(s);
    for (int p = 0; p < 2; p++) begin
      drop <= 7'(4 * (idx + 1) - p);
      wait_ev(1, 1, 300);
      gain_test_start <= 1'b1;
      @(posedge mclk);
      gain_test_start <= 1'b0;
      wait_ev(8, 1, 3);
      wait_ev(8, 0, 600);
      chk(gain_pass_q, p == 1 ? 48'h0 : key_enable);
    end
    give_verdict();
  end

  // Whole run is a few thousand cycles; this bound is far beyond it
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
